// ### rtl/atrc_defs.svh
// Register offsets, field positions, reset values and timing figures of the readout controller.
`ifndef ATRC_DEFS_SVH
`define ATRC_DEFS_SVH
`define ATRC_ANGLE_W 20
`define ATRC_TURN_W 24
`define ATRC_CLK_PERIOD_NS 8
`define ATRC_OFS_CTRL 8'h03
`define ATRC_OFS_STAT 8'h04
`define ATRC_OFS_VGAIN 8'h05
`define ATRC_OFS_AGAIN 8'h06
`define ATRC_OFS_FILT 8'h07
`define ATRC_OFS_WAKE 8'h08
`define ATRC_OFS_ANG_LO 8'h09
`define ATRC_OFS_ANG_HI 8'h0a
`define ATRC_OFS_TURN_LO 8'h0b
`define ATRC_OFS_TURN_HI 8'h0c
`define ATRC_OFS_RAW_LO 8'h0d
`define ATRC_OFS_RAW_HI 8'h0e
`define ATRC_CTRL_PREDICT_OFF 15
`define ATRC_CTRL_TEST_GO 13
`define ATRC_CTRL_BOOT_SKIP 12
`define ATRC_STAT_COIL_OPEN 13
`define ATRC_STAT_BATT 1
`define ATRC_STAT_BUSY 0
`define ATRC_PREDICT_OFF_RST 1'b1
`define ATRC_BOOT_SKIP_RST 1'b0
`define ATRC_GAIN_RST 16'h0000
`define ATRC_FILT_RST 4'h3
`define ATRC_WAKE_RST 16'h0100
`define ATRC_COIL_TEST_NS 10000
`define ATRC_BOOT_WAIT_NS 100000
`define ATRC_WAKE_UNIT_NS 1000
`define ATRC_WAKE_SETTLE_NS 2000
`endif

// ### rtl/atrc_pkg.sv
// State types of the readout controller.
`default_nettype none
package atrc_pkg;
  typedef enum logic [1:0] {TS_BOOT = 2'h0, TS_RUN = 2'h1, TS_IDLE = 2'h3} atrc_test_t;
  typedef enum logic [1:0] {BM_NORM = 2'h0, BM_SLEEP = 2'h1, BM_WAKE = 2'h3, BM_READ = 2'h2} atrc_batt_t;
endpackage : atrc_pkg
`default_nettype wire

// ### rtl/atrc_extrap_if.sv
// Signals between the readout controller and its angle prediction stage.
`default_nettype none
`include "atrc_defs.svh"
interface atrc_extrap_if;
  logic                      sample_vld;
  logic [`ATRC_ANGLE_W-1:0]  angle_raw;
  logic [15:0]               vel_gain;
  logic [15:0]               acc_gain;
  logic [3:0]                lpf_shift;
  logic                      predict_off;
  logic [`ATRC_ANGLE_W-1:0]  angle_out;
  logic                      angle_vld;
  modport ctrl (output sample_vld, angle_raw, vel_gain, acc_gain, lpf_shift, predict_off,
                input angle_out, angle_vld);
  modport extrap (input sample_vld, angle_raw, vel_gain, acc_gain, lpf_shift, predict_off,
                  output angle_out, angle_vld);
endinterface : atrc_extrap_if
`default_nettype wire

// ### rtl/atrc_extrap.sv
// Angle prediction stage: filtered angle plus gain-weighted velocity and acceleration.
`default_nettype none
`include "atrc_defs.svh"
module atrc_extrap #(
  parameter int FRAC = 8
) (
  input  wire logic   clk_in,
  input  wire logic   srst_in,
  atrc_extrap_if.extrap ex
);
  localparam int AW = `ATRC_ANGLE_W;
  localparam int PW = AW + 16;

  logic        [AW-1:0] prev_q;
  logic        [AW-1:0] ang_lpf_q;
  logic signed [AW-1:0] vel_lpf_q;
  logic signed [AW-1:0] vel_prev_q;
  logic signed [AW-1:0] acc_lpf_q;
  logic signed [AW-1:0] vel_raw;
  logic signed [AW-1:0] acc_raw;
  logic signed [AW-1:0] ang_err;
  logic signed [PW-1:0] kv_prod;
  logic signed [PW-1:0] ka_prod;
  logic        [AW-1:0] predicted;
  logic        [AW-1:0] angle_out_q;
  logic                 angle_vld_q;

  // Differences are taken modulo one turn, so a wrap through zero looks like a small step.
  assign vel_raw   = $signed(ex.angle_raw - prev_q);
  assign acc_raw   = vel_lpf_q - vel_prev_q;
  assign ang_err   = $signed(ex.angle_raw - ang_lpf_q);
  assign kv_prod   = $signed(ex.vel_gain) * vel_lpf_q;
  assign ka_prod   = $signed(ex.acc_gain) * acc_lpf_q;
  assign predicted = ang_lpf_q + kv_prod[AW+FRAC-1:FRAC] + ka_prod[AW+FRAC-1:FRAC];

  // First-order filters move by a power-of-two share of the error on every sample.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      prev_q     <= '0;
      ang_lpf_q  <= '0;
      vel_lpf_q  <= '0;
      vel_prev_q <= '0;
      acc_lpf_q  <= '0;
    end
    else if (ex.sample_vld)
    begin
      prev_q     <= ex.angle_raw;
      ang_lpf_q  <= ang_lpf_q + $unsigned(ang_err >>> ex.lpf_shift);
      vel_lpf_q  <= vel_lpf_q + ((vel_raw - vel_lpf_q) >>> ex.lpf_shift);
      vel_prev_q <= vel_lpf_q;
      acc_lpf_q  <= acc_lpf_q + ((acc_raw - acc_lpf_q) >>> ex.lpf_shift);
    end
  end

  // The bypass path hands the raw angle on untouched, with the same one-cycle latency.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      angle_out_q <= '0;
      angle_vld_q <= 1'b0;
    end
    else
    begin
      angle_vld_q <= ex.sample_vld;
      if (ex.sample_vld)
        angle_out_q <= ex.predict_off ? ex.angle_raw : predicted;
    end
  end

  assign ex.angle_out = angle_out_q;
  assign ex.angle_vld = angle_vld_q;

  default clocking chk_clk @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  chk_bypass_path: assert property (ex.sample_vld && ex.predict_off |=> ex.angle_out == $past(ex.angle_raw))
    else $error("Bypassed angle differs from the raw sample.");
  chk_predict_sum: assert property (ex.sample_vld && !ex.predict_off |=> ex.angle_out == $past(predicted))
    else $error("Predicted angle was not taken from the filter sum.");
  chk_out_timing: assert property (ex.angle_vld == $past(ex.sample_vld))
    else $error("Output strobe does not follow the sample strobe by one cycle.");
  chk_vel_hold: assert property (!ex.sample_vld |=> $stable(vel_lpf_q) && $stable(acc_lpf_q))
    else $error("Velocity filter moved without a sample.");
endmodule : atrc_extrap
`default_nettype wire

// ### rtl/atrc_readout_ctrl.sv
// Readout controller: angle and turn registers, open-coil test and battery wake sequencing.
// How it works
// - Position and turn data reach the controller as 16-bit register words.
// - Angle is unsigned 20-bit, 1,048,576 counts per revolution.
// - Signed 24-bit turn count, plus one clockwise, minus one counterclockwise.
// - An open coil found by the test sets status bit 13 at 0x04.
// - Writing one to control bit 13 at 0x03 starts the coil test at once.
// - The coil test runs at startup unless the boot-skip bit is one.
// - Predicted angle is filtered angle plus gain-weighted velocity and acceleration.
// - Velocity is low-pass filtered before it feeds the prediction.
// - Both prediction gains are writable by the controller.
// - Control bit 15 at 0x03 bypasses prediction and passes the raw angle.
// - Prediction stays bypassed after reset until the user enables it.
// - Raw sensor samples are readable for external calibration.
// - Main supply falling below battery switches the block to battery supply.
// - In battery mode the front end sleeps except for periodic readings.
// - The wake period is user set, trading current against tracked speed.
`default_nettype none
`include "atrc_defs.svh"
module atrc_readout_ctrl #(
  parameter int COILS         = 8,
  parameter int BOOT_WAIT_CYC = (`ATRC_BOOT_WAIT_NS + `ATRC_CLK_PERIOD_NS - 1) / `ATRC_CLK_PERIOD_NS
) (
  input  wire logic                     CLK_IN,
  input  wire logic                     SRST_IN,
  input  wire logic [7:0]               REG_ADDR_IN,
  input  wire logic [15:0]              REG_WDATA_IN,
  input  wire logic                     REG_WR_IN,
  input  wire logic                     REG_RD_IN,
  output logic      [15:0]              REG_RDATA_OUT,
  output logic                          REG_RVALID_OUT,
  input  wire logic [`ATRC_ANGLE_W-1:0] ANGLE_RAW_IN,
  input  wire logic                     ANGLE_VALID_IN,
  input  wire logic [COILS-1:0]         COIL_OPEN_IN,
  input  wire logic                     VCC_LOW_IN,
  output logic                          COIL_TEST_EN_OUT,
  output logic                          SUPPLY_BATT_OUT,
  output logic                          FE_SLEEP_OUT,
  output logic [`ATRC_ANGLE_W-1:0]      ANGLE_OUT,
  output logic                          ANGLE_VALID_OUT,
  output logic [`ATRC_TURN_W-1:0]       TURNS_OUT
);
  localparam int AW            = `ATRC_ANGLE_W;
  localparam int TW            = `ATRC_TURN_W;
  localparam int COIL_TEST_CYC = (`ATRC_COIL_TEST_NS + `ATRC_CLK_PERIOD_NS - 1) / `ATRC_CLK_PERIOD_NS;
  localparam int SETTLE_CYC    = (`ATRC_WAKE_SETTLE_NS + `ATRC_CLK_PERIOD_NS - 1) / `ATRC_CLK_PERIOD_NS;
  localparam int WAKE_UNIT_CYC = `ATRC_WAKE_UNIT_NS / `ATRC_CLK_PERIOD_NS;

  logic                   predict_off_q;
  logic                   boot_skip_q;
  logic [15:0]            vgain_q;
  logic [15:0]            again_q;
  logic [3:0]             filt_q;
  logic [15:0]            wake_q;
  logic [COILS-1:0]       coil_s1_q;
  logic [COILS-1:0]       coil_s2_q;
  logic                   vcc_s1_q;
  logic                   vcc_s2_q;
  atrc_pkg::atrc_test_t   tstate_q;
  logic [19:0]            tcnt_q;
  logic                   coil_open_q;
  atrc_pkg::atrc_batt_t   bstate_q;
  logic [22:0]            bcnt_q;
  logic [22:0]            wake_cyc;
  logic [AW-1:0]          last_q;
  logic [AW-1:0]          raw_q;
  logic                   have_q;
  logic [TW-1:0]          turns_q;
  logic [3:0]             snap_ang_hi_q;
  logic [3:0]             snap_raw_hi_q;
  logic [TW-1:0]          snap_turn_q;
  logic [15:0]            rd_mux;
  logic                   wr_ctrl;
  logic                   go_wr;
  logic                   test_busy;
  logic                   accept;
  logic                   wrap_up;
  logic                   wrap_dn;

  atrc_extrap_if ex_if ();

  assign wr_ctrl   = REG_WR_IN && (REG_ADDR_IN == `ATRC_OFS_CTRL);
  assign go_wr     = wr_ctrl && REG_WDATA_IN[`ATRC_CTRL_TEST_GO];
  assign test_busy = (tstate_q == atrc_pkg::TS_RUN);

  // Software-written configuration; the prediction bypass comes out of reset set.
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      predict_off_q <= `ATRC_PREDICT_OFF_RST;
      boot_skip_q   <= `ATRC_BOOT_SKIP_RST;
      vgain_q       <= `ATRC_GAIN_RST;
      again_q       <= `ATRC_GAIN_RST;
      filt_q        <= `ATRC_FILT_RST;
      wake_q        <= `ATRC_WAKE_RST;
    end
    else if (REG_WR_IN)
    begin
      case (REG_ADDR_IN)
        `ATRC_OFS_CTRL:
        begin
          predict_off_q <= REG_WDATA_IN[`ATRC_CTRL_PREDICT_OFF];
          boot_skip_q   <= REG_WDATA_IN[`ATRC_CTRL_BOOT_SKIP];
        end
        `ATRC_OFS_VGAIN: vgain_q <= REG_WDATA_IN;
        `ATRC_OFS_AGAIN: again_q <= REG_WDATA_IN;
        `ATRC_OFS_FILT:  filt_q  <= REG_WDATA_IN[3:0];
        `ATRC_OFS_WAKE:  wake_q  <= REG_WDATA_IN;
        default: ;
      endcase
    end
  end

  // Coil comparators and the supply comparator are asynchronous, so each passes two flops.
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      coil_s1_q <= '0;
      coil_s2_q <= '0;
      vcc_s1_q  <= 1'b0;
      vcc_s2_q  <= 1'b0;
    end
    else
    begin
      coil_s1_q <= COIL_OPEN_IN;
      coil_s2_q <= coil_s1_q;
      vcc_s1_q  <= VCC_LOW_IN;
      vcc_s2_q  <= vcc_s1_q;
    end
  end

  // Open-coil test sequencer. The boot wait gives the controller time to load its
  // configuration before the skip bit is judged; a start request cuts the wait short.
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      tstate_q    <= atrc_pkg::TS_BOOT;
      tcnt_q      <= 20'h00000;
      coil_open_q <= 1'b0;
    end
    else
    begin
      case (tstate_q)
        atrc_pkg::TS_BOOT, atrc_pkg::TS_IDLE:
        begin
          if (go_wr)
          begin
            tstate_q    <= atrc_pkg::TS_RUN;
            tcnt_q      <= 20'h00000;
            coil_open_q <= 1'b0;
          end
          else if (tstate_q == atrc_pkg::TS_BOOT)
          begin
            if (tcnt_q == 20'(BOOT_WAIT_CYC - 1))
            begin
              tstate_q <= boot_skip_q ? atrc_pkg::TS_IDLE : atrc_pkg::TS_RUN;
              tcnt_q   <= 20'h00000;
            end
            else
              tcnt_q <= tcnt_q + 20'h00001;
          end
        end
        atrc_pkg::TS_RUN:
        begin
          if (tcnt_q == 20'(COIL_TEST_CYC - 1))
          begin
            tstate_q    <= atrc_pkg::TS_IDLE;
            coil_open_q <= |coil_s2_q;
          end
          else
            tcnt_q <= tcnt_q + 20'h00001;
        end
        default: tstate_q <= atrc_pkg::TS_IDLE;
      endcase
    end
  end

  assign COIL_TEST_EN_OUT = test_busy;
  assign wake_cyc         = 23'(wake_q) * 23'(WAKE_UNIT_CYC);

  // Battery sequencer. A longer period saves charge but misses turns at higher speeds.
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      bstate_q <= atrc_pkg::BM_NORM;
      bcnt_q   <= 23'h000000;
    end
    else if (!vcc_s2_q)
    begin
      bstate_q <= atrc_pkg::BM_NORM;
      bcnt_q   <= 23'h000000;
    end
    else
    begin
      case (bstate_q)
        atrc_pkg::BM_NORM:
        begin
          bstate_q <= atrc_pkg::BM_SLEEP;
          bcnt_q   <= 23'h000000;
        end
        atrc_pkg::BM_SLEEP:
        begin
          if (bcnt_q + 23'h000001 >= wake_cyc)
          begin
            bstate_q <= atrc_pkg::BM_WAKE;
            bcnt_q   <= 23'h000000;
          end
          else
            bcnt_q <= bcnt_q + 23'h000001;
        end
        atrc_pkg::BM_WAKE:
        begin
          if (bcnt_q == 23'(SETTLE_CYC - 1))
            bstate_q <= atrc_pkg::BM_READ;
          else
            bcnt_q <= bcnt_q + 23'h000001;
        end
        atrc_pkg::BM_READ:
        begin
          if (ANGLE_VALID_IN)
          begin
            bstate_q <= atrc_pkg::BM_SLEEP;
            bcnt_q   <= 23'h000000;
          end
        end
        default: bstate_q <= atrc_pkg::BM_NORM;
      endcase
    end
  end

  assign SUPPLY_BATT_OUT = (bstate_q != atrc_pkg::BM_NORM);
  assign FE_SLEEP_OUT    = (bstate_q == atrc_pkg::BM_SLEEP);

  // Samples count only in normal mode or in the reading state after the wake settle.
  assign accept  = ANGLE_VALID_IN && (bstate_q == atrc_pkg::BM_NORM || bstate_q == atrc_pkg::BM_READ);
  assign wrap_up = have_q && last_q[AW-1:AW-2] == 2'h3 && ANGLE_RAW_IN[AW-1:AW-2] == 2'h0;
  assign wrap_dn = have_q && last_q[AW-1:AW-2] == 2'h0 && ANGLE_RAW_IN[AW-1:AW-2] == 2'h3;

  // Turn counter: a crossing of the top quadrant boundary is one whole turn.
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      last_q  <= '0;
      raw_q   <= '0;
      have_q  <= 1'b0;
      turns_q <= '0;
    end
    else if (accept)
    begin
      last_q <= ANGLE_RAW_IN;
      raw_q  <= ANGLE_RAW_IN;
      have_q <= 1'b1;
      if (wrap_up)
        turns_q <= turns_q + 24'h000001;
      else if (wrap_dn)
        turns_q <= turns_q - 24'h000001;
    end
  end

  assign TURNS_OUT = turns_q;

  assign ex_if.sample_vld  = accept;
  assign ex_if.angle_raw   = ANGLE_RAW_IN;
  assign ex_if.vel_gain    = vgain_q;
  assign ex_if.acc_gain    = again_q;
  assign ex_if.lpf_shift   = filt_q;
  assign ex_if.predict_off = predict_off_q;
  assign ANGLE_OUT         = ex_if.angle_out;
  assign ANGLE_VALID_OUT   = ex_if.angle_vld;

  atrc_extrap u_extrap (
    .clk_in  (CLK_IN),
    .srst_in (SRST_IN),
    .ex      (ex_if.extrap)
  );

  // Read multiplexer; high words and both turn words come from snapshots taken at the angle or raw low-word read.
  always_comb
  begin
    rd_mux = 16'h0000;
    case (REG_ADDR_IN)
      `ATRC_OFS_CTRL:
      begin
        rd_mux[`ATRC_CTRL_PREDICT_OFF] = predict_off_q;
        rd_mux[`ATRC_CTRL_TEST_GO]     = test_busy;
        rd_mux[`ATRC_CTRL_BOOT_SKIP]   = boot_skip_q;
      end
      `ATRC_OFS_STAT:
      begin
        rd_mux[`ATRC_STAT_COIL_OPEN] = coil_open_q;
        rd_mux[`ATRC_STAT_BATT]      = SUPPLY_BATT_OUT;
        rd_mux[`ATRC_STAT_BUSY]      = test_busy;
      end
      `ATRC_OFS_VGAIN:   rd_mux = vgain_q;
      `ATRC_OFS_AGAIN:   rd_mux = again_q;
      `ATRC_OFS_FILT:    rd_mux[3:0] = filt_q;
      `ATRC_OFS_WAKE:    rd_mux = wake_q;
      `ATRC_OFS_ANG_LO:  rd_mux = ex_if.angle_out[15:0];
      `ATRC_OFS_ANG_HI:  rd_mux[3:0] = snap_ang_hi_q;
      `ATRC_OFS_TURN_LO: rd_mux = snap_turn_q[15:0];
      `ATRC_OFS_TURN_HI: rd_mux[7:0] = snap_turn_q[TW-1:16];
      `ATRC_OFS_RAW_LO:  rd_mux = raw_q[15:0];
      `ATRC_OFS_RAW_HI:  rd_mux[3:0] = snap_raw_hi_q;
      default:           rd_mux = 16'h0000;
    endcase
  end

  // Registered read answer, one cycle after the strobe.
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      REG_RDATA_OUT  <= 16'h0000;
      REG_RVALID_OUT <= 1'b0;
      snap_ang_hi_q  <= 4'h0;
      snap_raw_hi_q  <= 4'h0;
      snap_turn_q    <= '0;
    end
    else
    begin
      REG_RVALID_OUT <= REG_RD_IN;
      REG_RDATA_OUT  <= REG_RD_IN ? rd_mux : 16'h0000;
      if (REG_RD_IN && REG_ADDR_IN == `ATRC_OFS_ANG_LO)
      begin
        snap_ang_hi_q <= ex_if.angle_out[AW-1:16];
        snap_turn_q   <= turns_q;
      end
      if (REG_RD_IN && REG_ADDR_IN == `ATRC_OFS_RAW_LO)
        snap_raw_hi_q <= raw_q[AW-1:16];
    end
  end

  // Helper that measures how long the coil test ran.
  logic [19:0] run_len_q;
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN || !test_busy)
      run_len_q <= 20'h00000;
    else
      run_len_q <= run_len_q + 20'h00001;
  end

  default clocking chk_clk @(posedge CLK_IN);
  endclocking
  default disable iff (SRST_IN);

  chk_go_starts: assert property (go_wr && tstate_q != atrc_pkg::TS_RUN |=> COIL_TEST_EN_OUT)
    else $error("Coil test did not start after the start write.");
  chk_test_length: assert property ($fell(test_busy) |-> $past(run_len_q) == 20'(COIL_TEST_CYC - 1))
    else $error("Coil test ran for the wrong number of cycles.");
  chk_open_flag: assert property ($fell(test_busy) && $past(|coil_s2_q) |-> rd_mux[`ATRC_STAT_COIL_OPEN] || REG_ADDR_IN != `ATRC_OFS_STAT)
    else $error("Open coil seen but status bit not set.");
  chk_boot_skip: assert property ($past(tstate_q) == atrc_pkg::TS_BOOT && test_busy && !$past(go_wr) |-> !$past(boot_skip_q))
    else $error("Startup test ran although skip was set.");
  chk_turn_up: assert property (accept && wrap_up |=> turns_q == $past(turns_q) + 24'h000001)
    else $error("Clockwise wrap did not add one turn.");
  chk_batt_enter: assert property (bstate_q == atrc_pkg::BM_NORM && vcc_s2_q |=> SUPPLY_BATT_OUT && FE_SLEEP_OUT)
    else $error("Supply loss did not enter battery sleep.");
  chk_wake_read: assert property (bstate_q == atrc_pkg::BM_READ && ANGLE_VALID_IN && vcc_s2_q |=> FE_SLEEP_OUT)
    else $error("Front end did not sleep after its reading.");
  chk_rdata_word: assert property (REG_RD_IN && REG_ADDR_IN == `ATRC_OFS_ANG_LO |=> REG_RVALID_OUT && REG_RDATA_OUT == $past(ANGLE_OUT[15:0]))
    else $error("Angle low word read back wrong.");
  chk_reset_bypass: assert property ($past(SRST_IN) |-> predict_off_q)
    else $error("Prediction not bypassed after reset.");
endmodule : atrc_readout_ctrl
`default_nettype wire

// ### tb/atrc_mcu_model.sv
// Register-bus master model standing in for the embedded controller.
`default_nettype none
module atrc_mcu_model (
  input  wire logic        clk_in,
  input  wire logic [15:0] rdata_in,
  input  wire logic        rvalid_in,
  output logic      [7:0]  addr_out,
  output logic      [15:0] wdata_out,
  output logic             wr_out,
  output logic             rd_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // The bus rests idle from time zero.
  initial
  begin
    addr_out  = 8'h00;
    wdata_out = 16'h0000;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end

  // One write strobe; released lines turn to their inverse so a stale value never looks valid.
  // Commands such as a coil test start arrive as such writes.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_in);
    addr_out  = a;
    wdata_out = d;
    wr_out    = 1'b1;
    @(negedge clk_in);
    wr_out    = 1'b0;
    addr_out  = ~a;
    wdata_out = ~d;
  endtask : wr

  // One read strobe; the answer stands for one cycle after the accepting edge, so it is taken mid-cycle.
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
    @(negedge clk_in);
    addr_out = a;
    rd_out   = 1'b1;
    @(negedge clk_in);
    d        = rdata_in;
    v        = rvalid_in;
    rd_out   = 1'b0;
    addr_out = ~a;
  endtask : rd
endmodule : atrc_mcu_model
`default_nettype wire

// ### tb/test_angle_turns_readout_ctrl.sv
// Self-checking bench of the angle and turn readout controller.
`default_nettype none
`include "atrc_defs.svh"
module test_angle_turns_readout_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BOOT  = 100;
  localparam int LIMIT = 20000;
  typedef struct packed { logic [7:0] a; logic [15:0] e; } atrc_row_t;
  logic        clk, srst, wr, rd, rvld, avld_in, vlow, avld, batt, fsleep, ten, v;
  logic [7:0]  addr, copen;
  logic [15:0] wdata, rdata, d;
  logic [19:0] araw, aout, r;
  logic [23:0] turns;
  int          fails, n_compared, cyc, n;
  atrc_row_t   rows [8];
  logic [19:0] sr [5] = '{20'h40000, 20'hf0000, 20'h00100, 20'hf0000, 20'h9abcd};
  logic [23:0] st [5] = '{24'h000000, 24'h000000, 24'h000001, 24'h000000, 24'h000000};
  logic [7:0]  ra [6] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e};
  logic [15:0] rm [6] = '{16'hffff, 16'h000f, 16'hffff, 16'h00ff, 16'hffff, 16'h000f};
  logic [15:0] re [6] = '{16'habcd, 16'h0009, 16'h0000, 16'h0000, 16'habcd, 16'h0009};

  atrc_mcu_model mcu (.clk_in(clk), .rdata_in(rdata), .rvalid_in(rvld), .addr_out(addr),
                      .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
  atrc_readout_ctrl #(.BOOT_WAIT_CYC(BOOT)) DUT (.CLK_IN(clk), .SRST_IN(srst), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvld),
    .ANGLE_RAW_IN(araw), .ANGLE_VALID_IN(avld_in), .COIL_OPEN_IN(copen), .VCC_LOW_IN(vlow),
    .COIL_TEST_EN_OUT(ten), .SUPPLY_BATT_OUT(batt), .FE_SLEEP_OUT(fsleep), .ANGLE_OUT(aout),
    .ANGLE_VALID_OUT(avld), .TURNS_OUT(turns));

  // Free-running clock of 8 ns.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Cuts a hang short; the ceiling is several times the expected run.
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == LIMIT)
    begin
      fails = fails + 1;
      $display("ERROR %0t timeout", $time);
      test_done();
    end
  end

  task automatic chk(input logic ok, input string msg);
    n_compared = n_compared + 1;
    if (ok !== 1'b1)
    begin
      fails = fails + 1;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : chk

  task automatic rst;
    srst = 1'b1;
    repeat (6) @(negedge clk);
    srst = 1'b0;
  endtask : rst

  // The sample line shows the inverse value once the strobe is gone; returns while the answer stands.
  task automatic smp(input logic [19:0] x);
    @(negedge clk);
    araw    = x;
    avld_in = 1'b1;
    @(negedge clk);
    avld_in = 1'b0;
    araw    = ~x;
  endtask : smp

  task automatic wait_test;
    n = 0;
    while (ten === 1'b1 && n < 1400)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_test

  task automatic test_done;
    $display("Compared %0d, errors %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  // Main sequence: register table, coil test, samples, prediction, boot skip, battery mode.
  initial
  begin
    srst = 1'b1;
    avld_in = 1'b0;
    araw = 20'h00000;
    vlow = 1'b0;
    copen = 8'h00;
    fails = 0;
    n_compared = 0;
    cyc = 0;
    rows = '{{8'h03, 16'h8000}, {8'h04, 16'h0000}, {8'h05, 16'h0000}, {8'h06, 16'h0000},
             {8'h07, 16'h0003}, {8'h08, 16'h0100}, {8'h00, 16'h0000}, {8'h0f, 16'h0000}};
    rst();
    chk({aout, avld, turns, batt, fsleep, ten, rvld, rdata} === 65'h0, "reset outputs");
    mcu.wr(8'h04, 16'hffff);
    mcu.wr(8'h0f, 16'hffff);
    foreach (rows[i])
    begin
      mcu.rd(rows[i].a, d, v);
      chk(v === 1'b1 && d === rows[i].e, "register reset value");
    end
    mcu.wr(8'h05, 16'h1000);
    mcu.wr(8'h06, 16'hff80);
    mcu.rd(8'h05, d, v);
    chk(d === 16'h1000, "velocity gain readback");
    mcu.rd(8'h06, d, v);
    chk(d === 16'hff80, "acceleration gain readback");
    n = 0;
    while (ten !== 1'b1 && n < BOOT + 50)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(ten === 1'b1, "startup coil test");
    mcu.rd(8'h03, d, v);
    chk(d[13] === 1'b1, "test bit while running");
    wait_test();
    mcu.rd(8'h03, d, v);
    chk(d[13] === 1'b0, "test bit after end");
    mcu.rd(8'h04, d, v);
    chk(d[13] === 1'b0, "no open coil");
    copen = 8'h04;
    mcu.wr(8'h03, 16'ha000);
    @(posedge clk);
    #1;
    chk(ten === 1'b1, "go starts test at once");
    wait_test();
    // The wait starts one edge into the 1250-cycle run, so it counts one cycle less.
    chk(n === 1249, "test length");
    mcu.rd(8'h04, d, v);
    chk(d[13] === 1'b1, "open coil flagged");
    copen = 8'h00;
    foreach (sr[i])
    begin
      smp(sr[i]);
      chk(avld === 1'b1 && aout === sr[i], "bypassed angle");
      @(posedge clk);
      #1;
      chk(turns === st[i], "turn count");
    end
    foreach (ra[i])
    begin
      mcu.rd(ra[i], d, v);
      chk((d & rm[i]) === re[i], "position word");
    end
    mcu.wr(8'h03, 16'h0000);
    for (int i = 0; i < 120; i++)
    begin
      r = 20'h20000 + 20'(i * 256);
      smp(r);
    end
    chk(aout > r + 20'h00100, "prediction leads a ramp");
    mcu.wr(8'h03, 16'h8000);
    smp(20'h31000);
    chk(aout === 20'h31000, "prediction bypassed again");
    rst();
    mcu.wr(8'h03, 16'h9000);
    n = 0;
    repeat (BOOT + 50)
    begin
      @(posedge clk);
      #1;
      if (ten === 1'b1)
        n++;
    end
    chk(n === 0, "startup test skipped");
    mcu.wr(8'h08, 16'h0001);
    vlow = 1'b1;
    n = 0;
    while (batt !== 1'b1 && n < 10)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(batt === 1'b1 && fsleep === 1'b1, "battery entry");
    n = 0;
    while (fsleep === 1'b1 && n < 300)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n >= 123 && n <= 127, "wake period");
    smp(20'h12345);
    chk(avld === 1'b0, "sample dropped while settling");
    repeat (260) @(posedge clk);
    smp(20'h23456);
    chk(avld === 1'b1 && aout === 20'h23456, "wake reading");
    @(posedge clk);
    #1;
    chk(fsleep === 1'b1, "asleep after reading");
    mcu.rd(8'h04, d, v);
    chk(d[1] === 1'b1, "battery status");
    vlow = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk(batt === 1'b0 && fsleep === 1'b0, "battery exit");
    test_done();
  end
endmodule : test_angle_turns_readout_ctrl
`default_nettype wire
